// file: tmr_pkg.sv
// Purpose: constants and types for the thermal monitor register bank
// Assumes: 100 MHz clk, two-wire slave port sampled on clk
// Notes: register map, bit positions, timing and types below
package tmr_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] PTR_CAP = 8'h00;
    localparam logic [7:0] PTR_CFG = 8'h01;
    localparam logic [7:0] PTR_HI = 8'h02;
    localparam logic [7:0] PTR_LO = 8'h03;
    localparam logic [7:0] PTR_CRIT = 8'h04;
    localparam logic [7:0] PTR_TEMP = 8'h05;
    localparam logic [7:0] PTR_MAKER = 8'h06;
    localparam logic [7:0] PTR_PART = 8'h07;
    localparam logic [7:0] PTR_RES = 8'h08;
    localparam logic [7:0] RST_PTR = 8'h00;
    localparam logic [15:0] RST_CAP = 16'h006F;
    localparam logic [15:0] RST_CFG = 16'h0001;
    localparam logic [15:0] RST_RES = 16'h0008;
    localparam logic [15:0] RST_LIM = 16'h0000;
    // Control word bit positions
    localparam int CFG_WIPE = 13;
    localparam int CFG_SEEN = 12;
    localparam int CFG_EN = 11;
    localparam int CFG_HYS = 9;
    localparam int CFG_POWER_DOWN_BIT = 8;
    localparam int CFG_CLK = 7;
    localparam int CFG_WLK = 6;
    localparam int CFG_CLR = 5;
    localparam int CFG_STS = 4;
    localparam int CFG_CTRL = 3;
    localparam int CFG_TONLY = 2;
    localparam int CFG_POL = 1;
    localparam int CFG_MODE = 0;
    localparam int CAP_POWER_DOWN_BIT = 7;
    // Upper five address bits, 0011 and a grounded A2
    localparam logic [4:0] ADDR_HI = 5'h06;
    // Hysteresis in quarter-degree steps
    localparam logic [11:0] HYS_0 = 12'h000;
    localparam logic [11:0] HYS_1 = 12'h006;
    localparam logic [11:0] HYS_2 = 12'h00C;
    localparam logic [11:0] HYS_3 = 12'h018;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int PULSE_MS = 160;
    localparam int TMO_MS = 30;
    localparam int PULSE_CYC = PULSE_MS * CLK_MHZ * 1000;
    localparam int TMO_CYC = TMO_MS * CLK_MHZ * 1000;
    localparam int CNT_W = 25;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
    } tmr_bus_t;
    typedef struct packed {
        logic hi;
        logic lo;
        logic crit;
    } tmr_zone_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK, ST_TX, ST_TACK
    } tmr_link_st_t;
    typedef enum logic [1:0] {
        PS_WAIT, PS_HOT, PS_PULSE
    } tmr_pulse_st_t;
endpackage

// file: tmr_bank.sv
// Purpose: two-wire slave register bank of a temperature monitor
// Assumes: pins and straps asynchronous, converter words on clk
// Notes: open-drain pins drive only low; oe_n low while driving
module tmr_bank
    import tmr_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int TIMEOUT_CYCLES = TMO_CYC,
    parameter logic POWER_DOWN_BIT_RELEASE = 1'b0,
    parameter logic [15:0] MAKER_CODE = 16'h1A2B, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h5C01 // arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Address straps
    input wire logic strap_select_zero,
    input wire logic strap_select_one,
    // Converter side
    input wire logic [15:0] temp_word,
    input wire logic temp_strobe,
    output logic power_down_bit,
    // Open-drain outputs
    output logic thermal_restart_pulse_out,
    output logic restart_oe_n,
    output logic alert_out,
    output logic alert_oe_n
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    tmr_bus_t bs1_q, bs2_q, bprev_q;
    logic [1:0] st1_q, st2_q;
    // Two flops for each pin; bprev only ever sees stage two
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bs1_q <= '{scl: 1'b1, sda: 1'b1};
            bs2_q <= '{scl: 1'b1, sda: 1'b1};
            bprev_q <= '{scl: 1'b1, sda: 1'b1};
            st1_q <= 2'h0;
            st2_q <= 2'h0;
        end else begin
            bs1_q <= '{scl: scl_in, sda: sda_in};
            bs2_q <= bs1_q;
            bprev_q <= bs2_q;
            st1_q <= {strap_select_one, strap_select_zero};
            st2_q <= st1_q;
        end
    end

    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = bs2_q.scl & ~bprev_q.scl;
    assign scl_fall = ~bs2_q.scl & bprev_q.scl;
    assign start_c = bs2_q.scl & bprev_q.scl & bprev_q.sda & ~bs2_q.sda;
    assign stop_c = bs2_q.scl & bprev_q.scl & ~bprev_q.sda & bs2_q.sda;

    // ----------------------------------------
    // Slave link state
    // ----------------------------------------
    tmr_link_st_t st_q, st_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, msb_q, msb_d;
    logic [1:0] idx_q, idx_d;
    logic rd_q, rd_d, oe_q, oe_d;
    logic [15:0] txw_q, txw_d;
    logic [CNT_W-1:0] tmo_q, tmo_d;
    logic [7:0] nb_c, ptr_q, ptr_d;
    logic ptr_we, word_we, tmo_hit;
    logic [15:0] wdat, rd_word;

    assign nb_c = {sh_q[6:0], bs2_q.sda};
    // Stuck-low clock releases the bus, active or powered down
    assign tmo_hit = (tmo_q == CNT_W'(TIMEOUT_CYCLES - 1));
    assign wdat = {msb_q, nb_c};

    // Byte engine: shift on rising clock, drive on falling clock
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        msb_d = msb_q;
        idx_d = idx_q;
        rd_d = rd_q;
        oe_d = oe_q;
        txw_d = txw_q;
        ptr_we = 1'b0;
        word_we = 1'b0;
        // No lower clock limit: waiting is unbounded except timeout
        tmo_d = (st_q != ST_IDLE && !bs2_q.scl) ? tmo_q + 1'b1 : '0;
        if (start_c) begin
            st_d = ST_ADDR;
            bit_d = 3'h0;
            idx_d = 2'h0;
            oe_d = 1'b1;
            tmo_d = '0;
        end else if (stop_c || tmo_hit) begin
            st_d = ST_IDLE;
            oe_d = 1'b1;
            tmo_d = '0;
        end else begin
            case (st_q)
                ST_ADDR: begin
                    if (scl_rise) begin
                        sh_d = nb_c;
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            // Strap ground reads 0, supply reads 1
                            if (nb_c[7:1] == {ADDR_HI, st2_q}) begin
                                st_d = ST_AACK;
                                rd_d = nb_c[0];
                                txw_d = rd_word;
                            end else begin
                                st_d = ST_IDLE;
                            end
                        end
                    end
                end
                ST_AACK, ST_RACK: begin
                    if (scl_fall) begin
                        if (oe_q) begin
                            oe_d = 1'b0;
                        end else if (st_q == ST_AACK && rd_q) begin
                            st_d = ST_TX;
                            bit_d = 3'h0;
                            oe_d = txw_q[15];
                            txw_d = {txw_q[14:0], 1'b0};
                        end else begin
                            st_d = ST_RX;
                            bit_d = 3'h0;
                            oe_d = 1'b1;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        sh_d = nb_c;
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            st_d = ST_RACK;
                            // First byte is the pointer, then MSB, LSB
                            case (idx_q)
                                2'h0: ptr_we = 1'b1;
                                2'h1: msb_d = nb_c;
                                2'h2: word_we = 1'b1;
                                default: ;
                            endcase
                            if (idx_q != 2'h3) begin
                                idx_d = idx_q + 2'h1;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        oe_d = txw_q[15];
                        txw_d = {txw_q[14:0], 1'b0};
                    end else if (scl_rise) begin
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            st_d = ST_TACK;
                        end
                    end
                end
                ST_TACK: begin
                    // Either ack or no-ack from the host is accepted
                    if (scl_fall) begin
                        oe_d = 1'b1;
                    end else if (scl_rise) begin
                        st_d = bs2_q.sda ? ST_IDLE : ST_TX;
                        bit_d = 3'h0;
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            msb_q <= 8'h00;
            idx_q <= 2'h0;
            rd_q <= 1'b0;
            oe_q <= 1'b1;
            txw_q <= 16'h0000;
            tmo_q <= '0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            msb_q <= msb_d;
            idx_q <= idx_d;
            rd_q <= rd_d;
            oe_q <= oe_d;
            txw_q <= txw_d;
            tmo_q <= tmo_d;
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [15:0] hi_q, hi_d, lo_q, lo_d, cr_q, cr_d;
    logic [15:0] res_q, res_d, tmp_q, tmp_d;
    logic seen_q, seen_d, en_q, en_d, power_down_bit_q, power_down_bit_d;
    logic clk_q, clk_d, wlk_q, wlk_d, ctrl_q, ctrl_d;
    logic tonly_q, tonly_d, pol_q, pol_d, mode_q, mode_d;
    logic [1:0] hys_q, hys_d;
    logic cfg_we, evt_clr, any_lock, evt_q, pulse_go;
    logic [15:0] cap_c, cfg_c;

    assign cfg_we = word_we && ptr_q == PTR_CFG;
    assign any_lock = clk_q | wlk_q;
    assign evt_clr = cfg_we & wdat[CFG_CLR];
    // Upper byte hard zero; low byte constant apart from flag
    assign cap_c = {RST_CAP[15:8], POWER_DOWN_BIT_RELEASE, RST_CAP[6:0]};
    // Wipe and clear bits read 0; reserved bits read 0
    always_comb begin
        cfg_c = 16'h0000;
        cfg_c[CFG_SEEN] = seen_q;
        cfg_c[CFG_EN] = en_q;
        cfg_c[CFG_HYS+:2] = hys_q;
        cfg_c[CFG_POWER_DOWN_BIT] = power_down_bit_q;
        cfg_c[CFG_CLK] = clk_q;
        cfg_c[CFG_WLK] = wlk_q;
        cfg_c[CFG_STS] = evt_q;
        cfg_c[CFG_CTRL] = ctrl_q;
        cfg_c[CFG_TONLY] = tonly_q;
        cfg_c[CFG_POL] = pol_q;
        cfg_c[CFG_MODE] = mode_q;
    end

    // Read mux by latched pointer; unmapped pointers read zero
    always_comb begin
        case (ptr_q)
            PTR_CAP: rd_word = cap_c;
            PTR_CFG: rd_word = cfg_c;
            PTR_HI: rd_word = hi_q;
            PTR_LO: rd_word = lo_q;
            PTR_CRIT: rd_word = cr_q;
            PTR_TEMP: rd_word = tmp_q;
            PTR_MAKER: rd_word = MAKER_CODE;
            PTR_PART: rd_word = PART_CODE;
            PTR_RES: rd_word = res_q;
            default: rd_word = 16'h0000;
        endcase
    end

    // Writes with lock rules; hardware set beats software wipe
    always_comb begin
        ptr_d = ptr_we ? nb_c : ptr_q;
        hi_d = hi_q;
        lo_d = lo_q;
        cr_d = cr_q;
        res_d = res_q;
        en_d = en_q;
        hys_d = hys_q;
        power_down_bit_d = power_down_bit_q;
        clk_d = clk_q;
        wlk_d = wlk_q;
        ctrl_d = ctrl_q;
        tonly_d = tonly_q;
        pol_d = pol_q;
        mode_d = mode_q;
        // Measured word frozen while powered down
        tmp_d = (temp_strobe && !power_down_bit_q) ? temp_word : tmp_q;
        seen_d = (seen_q & ~(cfg_we & wdat[CFG_WIPE])) | pulse_go;
        if (word_we) begin
            case (ptr_q)
                PTR_HI: if (!wlk_q) hi_d = wdat;
                PTR_LO: if (!wlk_q) lo_d = wdat;
                PTR_CRIT: if (!clk_q) cr_d = wdat;
                PTR_RES: res_d = wdat;
                PTR_CFG: begin
                    en_d = wdat[CFG_EN];
                    if (!any_lock) begin
                        hys_d = wdat[CFG_HYS+:2];
                        ctrl_d = wdat[CFG_CTRL];
                    end
                    if (!wdat[CFG_POWER_DOWN_BIT] || !any_lock) begin
                        power_down_bit_d = wdat[CFG_POWER_DOWN_BIT];
                    end
                    // Locks are set-only until power-on reset
                    clk_d = clk_q | wdat[CFG_CLK];
                    wlk_d = wlk_q | wdat[CFG_WLK];
                    if (!wlk_q) begin
                        tonly_d = wdat[CFG_TONLY];
                    end
                    pol_d = wdat[CFG_POL];
                    mode_d = wdat[CFG_MODE];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr_q <= RST_PTR;
            hi_q <= RST_LIM;
            lo_q <= RST_LIM;
            cr_q <= RST_LIM;
            res_q <= RST_RES;
            tmp_q <= 16'h0000;
            seen_q <= RST_CFG[CFG_SEEN];
            en_q <= RST_CFG[CFG_EN];
            hys_q <= RST_CFG[CFG_HYS+:2];
            power_down_bit_q <= RST_CFG[CFG_POWER_DOWN_BIT];
            clk_q <= RST_CFG[CFG_CLK];
            wlk_q <= RST_CFG[CFG_WLK];
            ctrl_q <= RST_CFG[CFG_CTRL];
            tonly_q <= RST_CFG[CFG_TONLY];
            pol_q <= RST_CFG[CFG_POL];
            mode_q <= RST_CFG[CFG_MODE];
        end else begin
            ptr_q <= ptr_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
            cr_q <= cr_d;
            res_q <= res_d;
            tmp_q <= tmp_d;
            seen_q <= seen_d;
            en_q <= en_d;
            hys_q <= hys_d;
            power_down_bit_q <= power_down_bit_d;
            clk_q <= clk_d;
            wlk_q <= wlk_d;
            ctrl_q <= ctrl_d;
            tonly_q <= tonly_d;
            pol_q <= pol_d;
            mode_q <= mode_d;
        end
    end

    // ----------------------------------------
    // Limit comparison and alert
    // ----------------------------------------
    tmr_zone_t zn_q, zn_d;
    logic int_q, int_d, evt_d, apin_q, apin_d, cond_c;
    logic signed [11:0] t_c, hi_c, lo_c, cr_c, hv_c;

    // Only bits 12:2 take part in the comparison
    assign t_c = {temp_word[12], temp_word[12:2]};
    assign hi_c = {hi_q[12], hi_q[12:2]};
    assign lo_c = {lo_q[12], lo_q[12:2]};
    assign cr_c = {cr_q[12], cr_q[12:2]};
    always_comb begin
        case (hys_q)
            2'h1: hv_c = HYS_1;
            2'h2: hv_c = HYS_2;
            2'h3: hv_c = HYS_3;
            default: hv_c = HYS_0;
        endcase
    end

    // Hysteresis only on the falling side of every limit
    always_comb begin
        zn_d = zn_q;
        if (temp_strobe && !power_down_bit_q) begin
            zn_d.hi = zn_q.hi ? !(t_c < hi_c - hv_c) : (t_c > hi_c);
            zn_d.crit = zn_q.crit ? !(t_c < cr_c - hv_c) : (t_c > cr_c);
            zn_d.lo = zn_q.lo ? (t_c < lo_c) : (t_c < lo_c - hv_c);
        end
        cond_c = zn_q.hi | zn_q.lo;
        // New window event latches; set beats the clear bit
        int_d = (int_q & ~evt_clr) | ((zn_d.hi & ~zn_q.hi) | (zn_d.lo & ~zn_q.lo));
        // Critical limit always acts as a comparator
        if (power_down_bit_q) begin
            evt_d = POWER_DOWN_BIT_RELEASE ? 1'b0 : evt_q;
        end else begin
            evt_d = ctrl_q & (zn_q.crit | (~tonly_q & (mode_q ? int_q : cond_c)));
        end
        // Pin level is asserted state xor inverted polarity; released outright in power-down if asked
        apin_d = (power_down_bit_q && POWER_DOWN_BIT_RELEASE) ? 1'b1 : ~(evt_d ^ pol_q);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            zn_q <= '0;
            int_q <= 1'b0;
            evt_q <= 1'b0;
            apin_q <= 1'b1;
        end else begin
            zn_q <= zn_d;
            int_q <= int_d;
            evt_q <= evt_d;
            apin_q <= apin_d;
        end
    end

    // ----------------------------------------
    // Restart pulse
    // ----------------------------------------
    tmr_pulse_st_t ps_q, ps_d;
    logic [CNT_W-1:0] pc_q, pc_d;
    logic roe_q, roe_d;

    // Arm above critical, fire when below low; pin hi-z if off
    always_comb begin
        ps_d = ps_q;
        pc_d = pc_q;
        pulse_go = 1'b0;
        case (ps_q)
            PS_WAIT: if (zn_q.crit) ps_d = PS_HOT;
            PS_HOT: begin
                if (zn_q.lo && en_q) begin
                    ps_d = PS_PULSE;
                    pc_d = '0;
                    pulse_go = 1'b1;
                end
            end
            PS_PULSE: begin
                pc_d = pc_q + 1'b1;
                if (pc_q == CNT_W'(PULSE_CYCLES - 1)) begin
                    ps_d = PS_WAIT;
                end
            end
            default: ps_d = PS_WAIT;
        endcase
        roe_d = ~(ps_d == PS_PULSE && en_q);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ps_q <= PS_WAIT;
            pc_q <= '0;
            roe_q <= 1'b1;
        end else begin
            ps_q <= ps_d;
            pc_q <= pc_d;
            roe_q <= roe_d;
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Open-drain: data is always low, the enable decides
    assign sda_out = 1'b0;
    assign sda_oe_n = oe_q;
    assign thermal_restart_pulse_out = 1'b0;
    assign restart_oe_n = roe_q;
    assign alert_out = 1'b0;
    assign alert_oe_n = apin_q;
    assign power_down_bit = power_down_bit_q;
endmodule // tmr_bank

// file: tmr_bank_monitor.sv
// Purpose: port checker for the thermal monitor register bank
// Assumes: one clock, synchronous active-low reset
// Notes: bound into tmr_bank after the module
module tmr_bank_monitor
    import tmr_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter logic POWER_DOWN_BIT_RELEASE = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched pins
    input wire logic scl_in,
    input wire logic sda_oe_n,
    input wire logic temp_strobe,
    input wire logic power_down_bit,
    input wire logic restart_oe_n,
    input wire logic alert_oe_n
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    int low_q;
    // Restart pin low time; a counter, since the pulse is far too long to unroll
    always_ff @(posedge clk) begin
        low_q <= (!rst_n || restart_oe_n) ? 0 : low_q + 1;
    end
    // A driven low stands for at least one bus phase
    AST_SDA_HOLD: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*4]) else $error("sda drive too short");
    AST_PULSE_HOLD: assert property ($fell(restart_oe_n) |=> !restart_oe_n [*8]) else $error("pulse cut short");
    // Power-down moves only on a word write, inside a clock high phase
    AST_PD_ON_WRITE: assert property ($changed(power_down_bit) |-> scl_in) else $error("pd moved off write");
    AST_RESET_IDLE: assert property ($rose(rst_n) |-> sda_oe_n && restart_oe_n && alert_oe_n && !power_down_bit)
        else $error("pins not idle after reset");
    AST_SDA_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_in) else $error("sda moved with scl high");
    AST_PULSE_MAX: assert property (!restart_oe_n |-> low_q < PULSE_CYCLES) else $error("pulse too long");
    AST_PULSE_MIN: assert property ($rose(restart_oe_n) |-> low_q >= PULSE_CYCLES)
        else $error("pulse too short");
    AST_PULSE_CAUSE: assert property ($fell(restart_oe_n) |-> $past(temp_strobe, 2))
        else $error("pulse without sample");
    AST_ALERT_POWER_DOWN_BIT: assert property (power_down_bit && $past(power_down_bit) |->
        (POWER_DOWN_BIT_RELEASE ? alert_oe_n : $stable(alert_oe_n))) else $error("alert moved in power-down");
    // Main scenarios reached
    cover property ($fell(sda_oe_n));
    cover property ($fell(restart_oe_n));
    cover property ($rose(power_down_bit));
endmodule // tmr_bank_monitor
bind tmr_bank tmr_bank_monitor #(.PULSE_CYCLES(PULSE_CYCLES), .POWER_DOWN_BIT_RELEASE(POWER_DOWN_BIT_RELEASE)) i_mon (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
    .temp_strobe(temp_strobe), .power_down_bit(power_down_bit),
    .restart_oe_n(restart_oe_n), .alert_oe_n(alert_oe_n));

// file: tmr_host.sv
// Purpose: two-wire bus host model
// Assumes: SDA has a pull-up; one bit takes 18 clk
// Notes: lines change 1 ns after a clk rise
module tmr_host (
    // Clock
    input wire logic clk,
    // Bus lines
    output logic scl,
    output logic sda_h,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    initial begin
        scl = 1'b1;
        sda_h = 1'b1;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // SDA moves only while SCL is low; sampled at the end of the high phase
    task automatic bx(input logic b, output logic r);
        sda_h = b;
        tk(6);
        scl = 1'b1;
        tk(8);
        r = sda;
        scl = 1'b0;
        tk(4);
    endtask
    // Also serves as repeated start
    task automatic start();
        sda_h = 1'b1;
        tk(4);
        scl = 1'b1;
        tk(8);
        sda_h = 1'b0;
        tk(8);
        scl = 1'b0;
        tk(4);
    endtask
    task automatic stop();
        sda_h = 1'b0;
        tk(4);
        scl = 1'b1;
        tk(8);
        sda_h = 1'b1;
        tk(8);
    endtask
    // Byte MSB first, then the acknowledge bit
    task automatic bt(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
        bx(ak, a);
    endtask
endmodule // tmr_host

// file: tmr_bank_tb.sv
// Purpose: self-checking bench for the thermal monitor register bank
// Assumes: host model on the two-wire port; short pulse and timeout
// Notes: every register access is a whole bus transfer
module tmr_bank_tb
    import tmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PC = 50;
    localparam logic [15:0] MK = 16'h1A2B; // arbitrary value
    localparam logic [15:0] PK = 16'h5C01; // arbitrary value
    localparam logic [15:0] EXP [10] = '{RST_CAP, RST_CFG, RST_LIM, RST_LIM, RST_LIM, 16'h0000, MK, PK, RST_RES,
        16'h0000};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] sa = 2'b10;
    logic [15:0] tw = 16'h0000;
    logic ts = 1'b0;
    logic scl, sda_h, sda_oe_n, pd, rpo, roe, ao, aoe, so, a;
    logic [15:0] q;
    wire logic sda = sda_h & sda_oe_n;
    int miscompares = 0;
    int comparisons = 0;
    // ----------------------------------------
    // Harness
    // ----------------------------------------
    initial forever #5 clk = ~clk;
    tmr_bank #(.PULSE_CYCLES(PC), .TIMEOUT_CYCLES(200)) i_dut (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe_n(sda_oe_n),
        .strap_select_zero(sa[0]), .strap_select_one(sa[1]), .temp_word(tw), .temp_strobe(ts),
        .power_down_bit(pd), .thermal_restart_pulse_out(rpo), .restart_oe_n(roe), .alert_out(ao),
        .alert_oe_n(aoe));
    tmr_host i_host (.clk(clk), .scl(scl), .sda_h(sda_h), .sda(sda));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic test_done();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Start and address byte for the current straps, which must be acknowledged
    task automatic ad(input logic rw);
        i_host.start();
        i_host.bt({ADDR_HI, sa, rw}, 1'b1, q[7:0], a);
        chk(16'(a), 16'h0000);
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        ad(1'b0);
        i_host.bt(p, 1'b1, q[7:0], a);
        i_host.bt(d[15:8], 1'b1, q[7:0], a);
        i_host.bt(d[7:0], 1'b1, q[7:0], a);
        i_host.stop();
    endtask
    // A negative pointer reads from the latched one
    task automatic rd(input int p, input logic [15:0] e);
        logic [15:0] r;
        if (p >= 0) begin
            ad(1'b0);
            i_host.bt(8'(p), 1'b1, q[7:0], a);
        end
        ad(1'b1);
        i_host.bt(8'hFF, 1'b0, r[15:8], a);
        i_host.bt(8'hFF, 1'b1, r[7:0], a);
        i_host.stop();
        chk(r, e);
    endtask
    task automatic smp(input logic [15:0] t);
        tw = t;
        ts = 1'b1;
        i_host.tk(1);
        ts = 1'b0;
        i_host.tk(3);
    endtask
    // Bounded wait on the restart pin
    task automatic wt(input logic v, input int n);
        for (int i = 0; i < n && roe !== v; i++) i_host.tk(1);
        chk(16'(roe), 16'(v));
        if (roe !== v) test_done();
    endtask
    task automatic rst();
        rst_n = 1'b0;
        i_host.tk(20);
        rst_n = 1'b1;
        i_host.tk(4);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        rst();
        rd(-1, RST_CAP);
        // Host parks SCL low while the slave drives; the slave must let go
        ad(1'b1);
        i_host.tk(250);
        chk(16'(sda), 16'h0001);
        i_host.stop();
        for (int p = 0; p < 10; p++) rd(p, EXP[p]);
        wr(PTR_CAP, 16'hFFFF);
        rd(PTR_CAP, RST_CAP);
        wr(PTR_CFG, 16'hE201);
        rd(PTR_CFG, 16'h0201);
        wr(PTR_RES, 16'h0003);
        rd(PTR_RES, 16'h0003);
        // Each strap code answers; the neighbouring address gets no ack
        for (int s = 0; s < 4; s++) begin
            sa = 2'(s);
            i_host.tk(8);
            rd(PTR_RES, 16'h0003);
            i_host.start();
            i_host.bt({ADDR_HI, sa ^ 2'b01, 1'b0}, 1'b1, q[7:0], a);
            chk(16'(a), 16'h0001);
            i_host.stop();
        end
        wr(PTR_CRIT, 16'h0200);
        wr(PTR_LO, 16'h0100);
        wr(PTR_HI, 16'h0300);
        wr(PTR_CFG, 16'h2000);
        smp(16'h0280);
        smp(16'h0080);
        chk(16'(roe), 16'h0001);
        smp(16'h0280);
        wr(PTR_CFG, 16'h0800);
        smp(16'h0080);
        wt(1'b0, 20);
        chk({13'h0000, so, rpo, ao}, 16'h0000);
        wt(1'b1, 4 * PC);
        rd(PTR_CFG, 16'h1800);
        wr(PTR_CFG, 16'h2800);
        rd(PTR_CFG, 16'h0800);
        // Alert keeps its level through power-down
        wr(PTR_CFG, 16'h0008);
        smp(16'h0400);
        chk(16'(aoe), 16'h0000);
        wr(PTR_CFG, 16'h0108);
        chk(16'(pd), 16'h0001);
        smp(16'h0200);
        chk(16'(aoe), 16'h0000);
        rd(PTR_TEMP, 16'h0400);
        // Six degrees of hysteresis keeps the critical zone below its limit
        wr(PTR_CFG, 16'h0608);
        smp(16'h0280);
        smp(16'h01C0);
        chk(16'(aoe), 16'h0000);
        smp(16'h0140);
        chk(16'(aoe), 16'h0001);
        // A lock freezes hysteresis until the next reset
        wr(PTR_CFG, 16'h0040);
        wr(PTR_CFG, 16'h0440);
        rd(PTR_CFG, 16'h0040);
        rst();
        rd(PTR_CFG, RST_CFG);
        test_done();
    end
endmodule // tmr_bank_tb
